// ### rtl/csod_bank.sv
// Channel status, user offset trim and sensor data0 register bank
module csod_bank #(
   parameter int TYPE_W = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic i2c_mode,
   input wire logic psi5_mode,
   input wire logic init_lock_bit,
   input wire logic [3:0] selftest_select,
   input wire logic psi5_selftest_start,
   input wire logic selftest_voltage_on,
   input wire logic psi5_startup_fail,
   input wire logic sinc_at_rail,
   input wire logic offset_limit_hit,
   input wire logic clip_tx_reported,
   input wire logic offset_tx_reported,
   input wire logic [2:0] cancel_phase_field,
   input wire logic [7:0] device_status,
   output logic device_status_read,
   input wire logic [TYPE_W-1:0] data0_type_select,
   input wire logic [(2**TYPE_W)*16-1:0] data0_sources,
   input wire logic [15:0] scaled_data,
   output logic [15:0] trimmed_data,
   output logic [15:0] user_offset_trim
);
   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   logic rd_stat;
   logic rd_mirror;
   logic rd_d0_lo;
   logic rd_d0_hi;
   assign rd_stat = reg_rd && hit(reg_addr, csod_pkg::OFS_CH_STAT);
   assign rd_mirror = reg_rd && hit(reg_addr, csod_pkg::OFS_MIRROR);
   assign rd_d0_lo = reg_rd && hit(reg_addr, csod_pkg::OFS_DATA0_LO);
   assign rd_d0_hi = reg_rd && hit(reg_addr, csod_pkg::OFS_DATA0_HI);
   assign device_status_read = rd_mirror;

   // ------------------------------------------------------------
   // Flag unit
   // ------------------------------------------------------------
   csod_flag_if fl ();
   csod_flag_unit u_flags (
      .clk(clk),
      .rst(rst),
      .fl(fl)
   );
   assign fl.clip_set = sinc_at_rail && !psi5_mode;
   assign fl.clip_tx_clr = clip_tx_reported && !psi5_mode;
   assign fl.offset_set = offset_limit_hit;
   assign fl.offset_tx_clr = offset_tx_reported;
   assign fl.clear_read = rd_stat;
   assign fl.pending_clr = (|selftest_select) || psi5_selftest_start;
   assign fl.stfail_set = psi5_startup_fail;

   logic running;
   assign running = (|selftest_select) || selftest_voltage_on;

   logic [7:0] stat_view;
   always_comb begin
      stat_view = 8'h00;
      stat_view[csod_pkg::BIT_CLIP] = fl.clip_flag;
      stat_view[csod_pkg::POS_PHASE +: 3] = cancel_phase_field;
      stat_view[csod_pkg::BIT_PENDING] = fl.pending_flag;
      stat_view[csod_pkg::BIT_RUNNING] = running;
      stat_view[csod_pkg::BIT_OFFSET] = fl.offset_flag;
      stat_view[csod_pkg::BIT_STFAIL] = fl.stfail_flag;
   end

   // ------------------------------------------------------------
   // User offset trim
   // ------------------------------------------------------------
   logic [15:0] trim;
   logic [15:0] next_trim;
   always_comb begin
      next_trim = trim;
      if (reg_wr && !init_lock_bit) begin
         if (hit(reg_addr, csod_pkg::OFS_TRIM_LO)) begin
            next_trim[7:0] = reg_wdata;
         end
         if (hit(reg_addr, csod_pkg::OFS_TRIM_HI)) begin
            next_trim[15:8] = reg_wdata;
         end
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trim <= csod_pkg::RST_TRIM;
      end else begin
         trim <= next_trim;
      end
   end
   // Trim bytes go out to the configuration array checker
   assign user_offset_trim = trim;

   // ------------------------------------------------------------
   // Data path: trim added after scaling, same LSB weight
   // ------------------------------------------------------------
   logic [15:0] sum;
   logic [15:0] next_sum;
   always_comb begin
      next_sum = 16'(scaled_data + trim);
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sum <= csod_pkg::RST_DATA0;
      end else begin
         sum <= next_sum;
      end
   end
   assign trimmed_data = sum;

   // ------------------------------------------------------------
   // Sensor data0 select and high byte latch
   // ------------------------------------------------------------
   logic [15:0] data0;
   assign data0 = data0_sources[data0_type_select*16 +: 16];

   logic [7:0] hi_hold;
   logic hi_held;
   logic [7:0] next_hi_hold;
   logic next_hi_held;
   always_comb begin
      next_hi_hold = hi_hold;
      next_hi_held = hi_held;
      if (rd_d0_hi) begin
         next_hi_held = 1'b0;
      end
      if (rd_d0_lo && i2c_mode) begin
         next_hi_hold = data0[15:8];
         next_hi_held = 1'b1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hi_hold <= csod_pkg::RST_DATA0[15:8];
         hi_held <= 1'b0;
      end else begin
         hi_hold <= next_hi_hold;
         hi_held <= next_hi_held;
      end
   end

   // ------------------------------------------------------------
   // Read data, one cycle after the read strobe
   // ------------------------------------------------------------
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = rdata;
      if (reg_rd) begin
         unique case (reg_addr)
            csod_pkg::OFS_TRIM_LO: next_rdata = trim[7:0];
            csod_pkg::OFS_TRIM_HI: next_rdata = trim[15:8];
            csod_pkg::OFS_CH_STAT: next_rdata = stat_view;
            csod_pkg::OFS_MIRROR: begin
               next_rdata = device_status;
               next_rdata[csod_pkg::BIT_MIRROR_RSVD] = 1'b0;
            end
            csod_pkg::OFS_DATA0_LO: next_rdata = data0[7:0];
            csod_pkg::OFS_DATA0_HI: begin
               next_rdata = (hi_held && i2c_mode) ? hi_hold : data0[15:8];
            end
            default: next_rdata = 8'h00;
         endcase
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 8'h00;
      end else begin
         rdata <= next_rdata;
      end
   end
   assign reg_rdata = rdata;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_trim_locked: assert property (
      @(posedge clk) disable iff (rst)
      init_lock_bit |=> trim == $past(trim))
      else $error("trim changed while locked");
   chk_trim_write: assert property (
      @(posedge clk) disable iff (rst)
      (reg_wr && !init_lock_bit && hit(reg_addr, csod_pkg::OFS_TRIM_HI))
         |=> trim[15:8] == $past(reg_wdata))
      else $error("trim high byte write lost");
   chk_trim_sum: assert property (
      @(posedge clk) disable iff (rst)
      1'b1 |=> trimmed_data == 16'($past(scaled_data) + $past(trim)))
      else $error("trimmed data not scaled plus trim");
   chk_hi_latched: assert property (
      @(posedge clk) disable iff (rst)
      (rd_d0_lo && i2c_mode) ##1 (!rd_d0_lo && !rd_d0_hi)
         ##1 (rd_d0_hi && i2c_mode)
         |=> reg_rdata == $past(data0[15:8], 3))
      else $error("high byte not taken from latch");
   chk_hi_pair: assert property (
      @(posedge clk) disable iff (rst)
      (rd_d0_lo && i2c_mode) ##1 (rd_d0_hi && i2c_mode)
         |=> reg_rdata == $past(data0[15:8], 2))
      else $error("high byte of pair not from latch");
   chk_status_write: assert property (
      @(posedge clk) disable iff (rst)
      (reg_wr && !reg_rd && hit(reg_addr, csod_pkg::OFS_CH_STAT)
         && !sinc_at_rail && !offset_limit_hit
         && !clip_tx_reported && !offset_tx_reported)
         |=> fl.clip_flag == $past(fl.clip_flag)
         && fl.offset_flag == $past(fl.offset_flag))
      else $error("write to status register cleared a flag");
   chk_mirror_read: assert property (
      @(posedge clk) disable iff (rst)
      rd_mirror |-> device_status_read
         ##1 reg_rdata == ($past(device_status) & 8'hbf))
      else $error("mirror read wrong");
   chk_psi5_clip: assert property (
      @(posedge clk) disable iff (rst)
      (psi5_mode && !fl.clip_flag && !rd_stat) |=> !fl.clip_flag)
      else $error("clip flag set in psi5 mode");
   chk_status_view: assert property (
      @(posedge clk) disable iff (rst)
      rd_stat |=> reg_rdata[csod_pkg::BIT_RUNNING] ==
         ($past(|selftest_select) || $past(selftest_voltage_on)))
      else $error("running bit wrong");
   chk_trim_low_write: assert property (
      @(posedge clk) disable iff (rst)
      (reg_wr && !init_lock_bit && hit(reg_addr, csod_pkg::OFS_TRIM_LO))
         |=> trim[7:0] == $past(reg_wdata))
      else $error("trim low byte write lost");
   chk_trim_read: assert property (
      @(posedge clk) disable iff (rst)
      (reg_rd && hit(reg_addr, csod_pkg::OFS_TRIM_HI))
         |=> reg_rdata == $past(trim[15:8]))
      else $error("trim high byte read wrong");
   chk_phase_view: assert property (
      @(posedge clk) disable iff (rst)
      rd_stat |=> reg_rdata[csod_pkg::POS_PHASE +: 3] ==
         $past(cancel_phase_field))
      else $error("cancel phase field wrong");
   chk_clip_set: assert property (
      @(posedge clk) disable iff (rst)
      (sinc_at_rail && !psi5_mode) |=> fl.clip_flag)
      else $error("clip flag not set at rail");
   chk_clip_tx_clear: assert property (
      @(posedge clk) disable iff (rst)
      (clip_tx_reported && !psi5_mode && !sinc_at_rail)
         |=> !fl.clip_flag)
      else $error("clip flag not cleared by transmission");
   chk_offset_set: assert property (
      @(posedge clk) disable iff (rst)
      offset_limit_hit |=> fl.offset_flag)
      else $error("offset flag not set at limit");
   chk_offset_tx_clear: assert property (
      @(posedge clk) disable iff (rst)
      (offset_tx_reported && !offset_limit_hit)
         |=> !fl.offset_flag)
      else $error("offset flag not cleared by transmission");
   chk_stfail_set: assert property (
      @(posedge clk) disable iff (rst)
      psi5_startup_fail |=> fl.stfail_flag)
      else $error("startup fail flag not set");
   chk_pending_clear: assert property (
      @(posedge clk) disable iff (rst)
      ((|selftest_select) || psi5_selftest_start)
         |=> !fl.pending_flag)
      else $error("pending flag kept after self-test start");
   chk_data0_low: assert property (
      @(posedge clk) disable iff (rst)
      rd_d0_lo |=> reg_rdata == $past(data0[7:0]))
      else $error("data0 low byte wrong");
   chk_hi_live: assert property (
      @(posedge clk) disable iff (rst)
      (rd_d0_hi && !i2c_mode) |=> reg_rdata == $past(data0[15:8]))
      else $error("data0 high byte not live");
   chk_latch_release: assert property (
      @(posedge clk) disable iff (rst)
      (rd_d0_hi && !rd_d0_lo) |=> !hi_held)
      else $error("high byte latch not released");
   chk_data_write: assert property (
      @(posedge clk) disable iff (rst)
      (reg_wr && reg_addr[7:4] == 4'h6)
         |=> trim == $past(trim))
      else $error("write to status or data changed trim");

   cov_clip_read: cover property (
      @(posedge clk) disable iff (rst)
      fl.clip_flag ##1 rd_stat ##1 !fl.clip_flag);
   cov_i2c_pair: cover property (
      @(posedge clk) disable iff (rst)
      (rd_d0_lo && i2c_mode) ##1 (rd_d0_hi && i2c_mode));
   cov_trim_lock: cover property (
      @(posedge clk) disable iff (rst)
      (reg_wr && !init_lock_bit) ##[1:10] init_lock_bit);
   cov_stfail_hold: cover property (
      @(posedge clk) disable iff (rst)
      fl.stfail_flag ##1 rd_stat ##1 fl.stfail_flag);
   cov_pending_clear: cover property (
      @(posedge clk) disable iff (rst)
      fl.pending_flag ##1 !fl.pending_flag);
endmodule : csod_bank

// ### rtl/csod_flag_if.sv
// Set and clear strobes and sticky flag values between bank and flag unit
interface csod_flag_if;
   logic clip_set;
   logic offset_set;
   logic clear_read;
   logic clip_tx_clr;
   logic offset_tx_clr;
   logic pending_clr;
   logic stfail_set;
   logic clip_flag;
   logic offset_flag;
   logic pending_flag;
   logic stfail_flag;
   modport bank (
      output clip_set, offset_set, clear_read, clip_tx_clr, offset_tx_clr,
      output pending_clr, stfail_set,
      input clip_flag, offset_flag, pending_flag, stfail_flag
   );
   modport unit (
      input clip_set, offset_set, clear_read, clip_tx_clr, offset_tx_clr,
      input pending_clr, stfail_set,
      output clip_flag, offset_flag, pending_flag, stfail_flag
   );
endinterface : csod_flag_if

// ### rtl/csod_flag_unit.sv
// Sticky channel status flags
module csod_flag_unit (
   input wire logic clk,
   input wire logic rst,
   csod_flag_if.unit fl
);
   logic clip_flag;
   logic offset_flag;
   logic pending_flag;
   logic stfail_flag;
   logic next_clip_flag;
   logic next_offset_flag;
   logic next_pending_flag;
   logic next_stfail_flag;

   // ------------------------------------------------------------
   // Flag update, set beats clear
   // ------------------------------------------------------------
   always_comb begin
      next_clip_flag = clip_flag;
      next_offset_flag = offset_flag;
      next_pending_flag = pending_flag;
      next_stfail_flag = stfail_flag;
      if (fl.clear_read || fl.clip_tx_clr) begin
         next_clip_flag = 1'b0;
      end
      if (fl.clip_set) begin
         next_clip_flag = 1'b1;
      end
      if (fl.clear_read || fl.offset_tx_clr) begin
         next_offset_flag = 1'b0;
      end
      if (fl.offset_set) begin
         next_offset_flag = 1'b1;
      end
      if (fl.pending_clr) begin
         next_pending_flag = 1'b0;
      end
      if (fl.stfail_set) begin
         next_stfail_flag = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clip_flag <= csod_pkg::RST_CH_STAT[csod_pkg::BIT_CLIP];
         offset_flag <= csod_pkg::RST_CH_STAT[csod_pkg::BIT_OFFSET];
         pending_flag <= csod_pkg::RST_CH_STAT[csod_pkg::BIT_PENDING];
         stfail_flag <= csod_pkg::RST_CH_STAT[csod_pkg::BIT_STFAIL];
      end else begin
         clip_flag <= next_clip_flag;
         offset_flag <= next_offset_flag;
         pending_flag <= next_pending_flag;
         stfail_flag <= next_stfail_flag;
      end
   end

   assign fl.clip_flag = clip_flag;
   assign fl.offset_flag = offset_flag;
   assign fl.pending_flag = pending_flag;
   assign fl.stfail_flag = stfail_flag;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_set_beats_clear: assert property (
      @(posedge clk) disable iff (rst)
      (fl.clip_set || fl.offset_set) |=>
         (!$past(fl.clip_set) || clip_flag) &&
         (!$past(fl.offset_set) || offset_flag))
      else $error("flag lost when set met clear");
   chk_read_clears: assert property (
      @(posedge clk) disable iff (rst)
      (fl.clear_read && !fl.offset_set && !fl.clip_set) |=>
         !offset_flag && !clip_flag)
      else $error("status read left a flag set");
   chk_stfail_sticky: assert property (
      @(posedge clk) disable iff (rst)
      stfail_flag |=> stfail_flag)
      else $error("startup fail flag cleared without reset");
   chk_pending_drop: assert property (
      @(posedge clk) disable iff (rst)
      fl.pending_clr |=> !pending_flag ##1 !pending_flag)
      else $error("pending flag not cleared");
endmodule : csod_flag_unit

// ### rtl/csod_pkg.sv
// Constants for the channel status, offset trim and data register bank
// Behaviour
// - Signed 16-bit offset trim in two bytes, writable only until init lock.
// - Trim is added to scaled data ahead of offset cancellation.
// - One trim LSB moves the reported data by exactly one LSB.
// - Both trim bytes feed the configuration array error check.
// - Pending flag sets on reset, clears on any select bit or PSI5 test start.
// - Outside PSI5, clip flag sets when sinc output hits either rail.
// - Clip flag clears on status read or on a transmission reporting it.
// - In PSI5 mode the clip flag has no effect on anything.
// - Three-bit cancel phase field: 0-5 phases, 6 normal, 7 unused.
// - Running flag is OR of four select bits and applied test voltage.
// - Offset flag sets at offset limit, clears like the clip flag.
// - Startup self-test fail flag stays set until device reset.
// - Mirror returns device status bits and triggers the same read effects.
// - Read-only 16-bit data0 in two bytes, type picked by select field.
// - In I2C mode a low-byte read latches high byte until high read.
package csod_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_TRIM_LO = 8'h55;
   localparam logic [7:0] OFS_TRIM_HI = 8'h56;
   localparam logic [7:0] OFS_CH_STAT = 8'h60;
   localparam logic [7:0] OFS_MIRROR = 8'h61;
   localparam logic [7:0] OFS_DATA0_LO = 8'h62;
   localparam logic [7:0] OFS_DATA0_HI = 8'h63;
   // ------------------------------------------------------------
   // Channel status fields and reset values
   // ------------------------------------------------------------
   localparam int BIT_CLIP = 7;
   localparam int POS_PHASE = 4;
   localparam int BIT_PENDING = 3;
   localparam int BIT_RUNNING = 2;
   localparam int BIT_OFFSET = 1;
   localparam int BIT_STFAIL = 0;
   localparam int BIT_MIRROR_RSVD = 6;
   localparam logic [7:0] RST_CH_STAT = 8'h08;
   localparam logic [15:0] RST_TRIM = 16'h0000;
   localparam logic [15:0] RST_DATA0 = 16'h0000;
   localparam logic [2:0] PHASE_UNUSED = 3'h7;
   localparam logic [2:0] PHASE_NORMAL = 3'h6;
endpackage : csod_pkg

// ### tb/channel_status_offset_data_regs_bench.sv
// Self-checking bench for the channel status, trim and data0 bank
module channel_status_offset_data_regs_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic reg_wr, reg_rd, dsr;
   logic i2c_mode = 1'b0, psi5_mode = 1'b0, init_lock_bit = 1'b0;
   logic [3:0] selftest_select = 4'h0;
   logic psi5_selftest_start = 1'b0, selftest_voltage_on = 1'b0;
   logic psi5_startup_fail = 1'b0, sinc_at_rail = 1'b0;
   logic offset_limit_hit = 1'b0, clip_tx_reported = 1'b0;
   logic offset_tx_reported = 1'b0;
   logic [2:0] cancel_phase_field = 3'h0;
   logic [7:0] device_status = 8'h00;
   logic [1:0] data0_type_select = 2'h0;
   logic [63:0] data0_sources = 64'h0;
   logic [15:0] scaled_data = 16'h0100, trimmed_data, user_offset_trim;
   int fail_count = 0;
   int checked = 0;
   always #50 clk = ~clk;
   csod_bank csod_bank_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .i2c_mode(i2c_mode), .psi5_mode(psi5_mode),
      .init_lock_bit(init_lock_bit), .selftest_select(selftest_select),
      .psi5_selftest_start(psi5_selftest_start),
      .selftest_voltage_on(selftest_voltage_on),
      .psi5_startup_fail(psi5_startup_fail), .sinc_at_rail(sinc_at_rail),
      .offset_limit_hit(offset_limit_hit),
      .clip_tx_reported(clip_tx_reported),
      .offset_tx_reported(offset_tx_reported),
      .cancel_phase_field(cancel_phase_field),
      .device_status(device_status), .device_status_read(dsr),
      .data0_type_select(data0_type_select), .data0_sources(data0_sources),
      .scaled_data(scaled_data), .trimmed_data(trimmed_data),
      .user_offset_trim(user_offset_trim));
   csod_host_model csod_host_model_inst (.clk(clk), .reg_rdata(reg_rdata),
      .device_status_read(dsr), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata));
   // ------------------------------------------------------------
   // Shared helpers
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      checked++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask : chk
   task automatic rd(input logic [7:0] a);
      csod_host_model_inst.rd(a, d);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      csod_host_model_inst.wr(a, v);
   endtask : wr
   task automatic pulse(ref logic s);
      @(negedge clk) s = 1'b1;
      @(negedge clk) s = 1'b0;
   endtask : pulse
   task automatic do_reset();
      @(negedge clk) rst = 1'b1;
      repeat (16) @(negedge clk);
      rst = 1'b0;
   endtask : do_reset
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset_values();
      rd(8'h60);
      chk("status reset", 16'h0008, d);
      rd(8'h55);
      chk("trim low reset", 16'h0000, d);
      chk("trim out reset", 16'h0000, user_offset_trim);
      rd(8'h63);
      chk("data0 high reset", 16'h0000, d);
      rd(8'h70);
      chk("unmapped read", 16'h0000, d);
   endtask : t_reset_values
   task automatic t_trim();
      wr(8'h55, 8'hff);
      wr(8'h56, 8'hff);
      chk("trim out", 16'hffff, user_offset_trim);
      @(negedge clk);
      chk("trimmed minus one", 16'h00ff, trimmed_data);
      wr(8'h55, 8'h01);
      wr(8'h56, 8'h00);
      @(negedge clk);
      chk("trimmed plus one", 16'h0101, trimmed_data);
      rd(8'h56);
      chk("trim high", 16'h0000, d);
      init_lock_bit = 1'b1;
      wr(8'h55, 8'haa);
      wr(8'h56, 8'h55);
      rd(8'h55);
      chk("locked trim low", 16'h0001, d);
      chk("locked trim out", 16'h0001, user_offset_trim);
   endtask : t_trim
   task automatic t_flags();
      for (int p = 0; p < 7; p++) begin
         cancel_phase_field = p[2:0];
         rd(8'h60);
         chk("phase", 16'(p), 16'(d[6:4]));
      end
      pulse(sinc_at_rail);
      rd(8'h60);
      chk("clip set", 16'h1, 16'(d[7]));
      rd(8'h60);
      chk("clip read clear", 16'h0, 16'(d[7]));
      @(negedge clk) sinc_at_rail = 1'b1;
      rd(8'h60);
      sinc_at_rail = 1'b0;
      rd(8'h60);
      chk("clip set beats clear", 16'h1, 16'(d[7]));
      pulse(sinc_at_rail);
      wr(8'h60, 8'h00);
      rd(8'h60);
      chk("status write ignored", 16'h1, 16'(d[7]));
      pulse(sinc_at_rail);
      pulse(clip_tx_reported);
      rd(8'h60);
      chk("clip tx clear", 16'h0, 16'(d[7]));
      pulse(offset_limit_hit);
      rd(8'h60);
      chk("offset set", 16'h1, 16'(d[1]));
      rd(8'h60);
      chk("offset read clear", 16'h0, 16'(d[1]));
      pulse(offset_limit_hit);
      pulse(offset_tx_reported);
      rd(8'h60);
      chk("offset tx clear", 16'h0, 16'(d[1]));
      @(negedge clk) offset_limit_hit = 1'b1;
      rd(8'h60);
      offset_limit_hit = 1'b0;
      rd(8'h60);
      chk("offset set beats clear", 16'h1, 16'(d[1]));
      psi5_mode = 1'b1;
      pulse(sinc_at_rail);
      rd(8'h60);
      chk("clip in psi5", 16'h0, 16'(d[7]));
      psi5_mode = 1'b0;
      pulse(sinc_at_rail);
      psi5_mode = 1'b1;
      pulse(clip_tx_reported);
      psi5_mode = 1'b0;
      rd(8'h60);
      chk("clip kept in psi5", 16'h1, 16'(d[7]));
   endtask : t_flags
   task automatic t_selftest();
      for (int i = 0; i < 4; i++) begin
         do_reset();
         selftest_select = 4'h1 << i;
         rd(8'h60);
         chk("running select", 16'h1, 16'(d[2]));
         chk("pending cleared", 16'h0, 16'(d[3]));
         selftest_select = 4'h0;
         rd(8'h60);
         chk("running idle", 16'h0, 16'(d[2]));
      end
      selftest_voltage_on = 1'b1;
      rd(8'h60);
      chk("running voltage", 16'h1, 16'(d[2]));
      selftest_voltage_on = 1'b0;
      do_reset();
      rd(8'h60);
      chk("pending after reset", 16'h1, 16'(d[3]));
      pulse(psi5_selftest_start);
      rd(8'h60);
      chk("pending psi5 start", 16'h0, 16'(d[3]));
      pulse(psi5_startup_fail);
      rd(8'h60);
      rd(8'h60);
      chk("fail sticky", 16'h1, 16'(d[0]));
      do_reset();
      rd(8'h60);
      chk("fail reset", 16'h0, 16'(d[0]));
   endtask : t_selftest
   task automatic t_mirror();
      logic seen;
      device_status = 8'hff;
      rd(8'h61);
      chk("mirror", 16'h00bf, d);
      seen = csod_host_model_inst.last_dsr;
      chk("mirror read effect", 16'h1, 16'(seen));
      device_status = 8'h5a;
      rd(8'h61);
      chk("mirror reserved", 16'h001a, d);
      rd(8'h60);
      seen = csod_host_model_inst.last_dsr;
      chk("no mirror effect", 16'h0, 16'(seen));
   endtask : t_mirror
   task automatic t_data();
      data0_sources = 64'ha353a252a151a050;
      for (int k = 0; k < 4; k++) begin
         @(negedge clk) data0_type_select = k[1:0];
         rd(8'h62);
         chk("data0 low", 16'(8'h50 + k), d);
         rd(8'h63);
         chk("data0 high", 16'(8'ha0 + k), d);
      end
      wr(8'h62, 8'hff);
      rd(8'h62);
      chk("data write ignored", 16'h0053, d);
      i2c_mode = 1'b1;
      data0_type_select = 2'h0;
      rd(8'h62);
      data0_sources[15:0] = 16'hbeef;
      rd(8'h63);
      chk("i2c latched high", 16'h00a0, d);
      rd(8'h63);
      chk("i2c live high", 16'h00be, d);
      i2c_mode = 1'b0;
      rd(8'h62);
      data0_sources[15:0] = 16'hcafe;
      rd(8'h63);
      chk("live high outside i2c", 16'h00ca, d);
   endtask : t_data
   initial begin
      repeat (3000) @(posedge clk);
      fail_count++;
      final_report();
   end
   initial begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      t_reset_values();
      t_trim();
      t_flags();
      t_selftest();
      t_mirror();
      t_data();
      final_report();
   end
endmodule : channel_status_offset_data_regs_bench

// ### tb/csod_host_model.sv
// Host controller model driving the register port of the bank
module csod_host_model (
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   input wire logic device_status_read,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last_dsr;
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
      last_dsr = 1'b0;
   end
   // ------------------------------------------------------------
   // Bus cycles
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      // Released lines never keep the last value
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
   endtask : wr
   // Each read strobes one address for one cycle; successive reads leave one idle cycle between strobes
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      last_dsr = device_status_read;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~reg_addr;
      d = reg_rdata;
   endtask : rd
endmodule : csod_host_model
